// ### testbench/sysref_source.sv
// External clock source model driving SYSREF views per delay tap
`timescale 1ns/1ps
`default_nettype none
module sysref_source (
    // Clock and control
    input wire logic i_clk,
    input wire logic i_fire,
    input wire logic [4:0] i_pos,
    // SYSREF as seen at each delay tap
    output logic [23:0] o_taps
);
    // Edge lands between taps pos-1 and pos; SYSREF low between pulses
    always_ff @(posedge i_clk) begin
        o_taps <= i_fire ? (24'hffffff << i_pos) : 24'h000000;
    end
endmodule // sysref_source
`default_nettype wire

// ### testbench/tb.sv
// Self-checking bench for the SYSREF capture windowing block
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic i_clk = 0, i_resetn = 0, rd = 0, wr = 0, fire = 0, rd_d = 0;
    logic fine, crst;
    logic [11:0] addr = 0;
    logic [7:0] wdata = 0, rdata;
    logic [4:0] pos = 0;
    logic [3:0] sel;
    logic [23:0] taps, st;
    logic [7:0] expq[$];
    int num_errors = 0, num_checks = 0, pulses = 0, seed = 32'h3f07;
    sysref_source src_u (.i_clk(i_clk), .i_fire(fire), .i_pos(pos),
        .o_taps(taps));
    sysref_capture_windowing dut_u (.i_clk(i_clk), .i_resetn(i_resetn),
        .i_tap_samples(taps), .o_tap_step_fine(fine), .i_reg_addr(addr),
        .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_wdata(wdata),
        .o_reg_rdata(rdata), .o_counter_reset(crst));
    task automatic report_and_stop;
        if (num_errors == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic rd_reg(input logic [11:0] a, input logic [7:0] e);
        @(posedge i_clk);
        addr <= a;
        rd <= 1'b1;
        expq.push_back(e);
        @(posedge i_clk);
        rd <= 1'b0;
    endtask
    task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
        @(posedge i_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge i_clk);
        wr <= 1'b0;
    endtask
    initial begin
        forever #5 i_clk = ~i_clk;
    end
    // Read data lands one cycle after the read strobe
    always @(posedge i_clk) begin
        if (rd_d) check(rdata, expq.pop_front());
        rd_d <= rd;
        if (crst === 1'b1) pulses++;
    end
    initial begin
        #400000;
        num_errors++;
        report_and_stop();
    end
    initial begin
        repeat (20) @(posedge i_clk);
        i_resetn <= 1'b1;
        check({7'h00, fine}, 8'h01);
        rd_reg(12'h029, 8'h00);
        rd_reg(12'h02a, 8'h01);
        rd_reg(12'h02c, 8'hff);
        rd_reg(12'h02e, 8'hff);
        rd_reg(12'h030, 8'h00);
        wr_reg(12'h02a, 8'h00);
        @(negedge i_clk);
        check({7'h00, fine}, 8'h00);
        rd_reg(12'h02a, 8'h00);
        wr_reg(12'h02a, 8'hff);
        wr_reg(12'h02c, 8'h00);
        rd_reg(12'h02c, 8'hff);
        for (int n = 0; n < 16; n++) begin
            pos = 5'd1 + 5'($unsigned($random(seed)) % 22);
            sel = 4'($random(seed));
            wr_reg(12'h029, {4'ha, sel});
            pulses = 0;
            @(posedge i_clk);
            fire <= 1'b1;
            repeat (4) @(posedge i_clk);
            fire <= 1'b0;
            repeat (8) @(posedge i_clk);
            check(8'(pulses), 8'(sel >= pos));
            st = 24'h800001 | (24'h000003 << (pos - 5'd1));
            rd_reg(12'h02c, st[7:0]);
            rd_reg(12'h02d, st[15:8]);
            rd_reg(12'h02e, st[23:16]);
            rd_reg(12'h029, {4'h0, sel});
        end
        // Mid-run reset, then a stored tap restored as at power-up
        @(posedge i_clk);
        i_resetn <= 1'b0;
        repeat (2) @(posedge i_clk);
        i_resetn <= 1'b1;
        check({7'h00, fine}, 8'h01);
        rd_reg(12'h02c, 8'hff);
        rd_reg(12'h029, 8'h00);
        pos = 5'd4;
        // Valid zeros run from 5 up; middle of the reachable part is 10
        wr_reg(12'h029, 8'h0a);
        pulses = 0;
        @(posedge i_clk);
        fire <= 1'b1;
        repeat (4) @(posedge i_clk);
        fire <= 1'b0;
        repeat (8) @(posedge i_clk);
        check(8'(pulses), 8'h01);
        rd_reg(12'h02c, 8'h19);
        repeat (3) @(posedge i_clk);
        report_and_stop();
    end
endmodule // tb
`default_nettype wire

// ### verilog/sysref_capture_windowing.sv
// SYSREF position detector and selectable capture tap
`timescale 1ns/1ps
`default_nettype none
module sysref_capture_windowing (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_resetn,
    // SYSREF as seen at each delayed clock position, from the delay line
    input wire logic [23:0] i_tap_samples,
    // Delay line step control
    output logic o_tap_step_fine,
    // Register port
    input wire logic [11:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    // Multiframe / extended multiblock counter reset
    output logic o_counter_reset
);
    // Position i is a hazard when a neighbour saw a different level
    function automatic logic [23:0] hazard_of(input logic [23:0] s);
        logic [23:0] h;
        h = '0;
        for (int i = 1; i < 23; i++) begin
            h[i] = (s[i] != s[i-1]) || (s[i] != s[i+1]);
        end
        return h | sysref_window_pkg::STATUS_END_MASK;
    endfunction

    logic [23:0] sync1_reg;
    logic [23:0] sync2_reg;
    logic [23:0] prev_reg;
    logic [23:0] status_reg;
    logic [3:0] sel_reg;
    logic fine_reg;
    logic [7:0] rdata_reg;
    logic counter_reset_reg;

    wire edge_seen = |(sync2_reg & ~prev_reg);
    wire sel_rise = sync2_reg[sel_reg] & ~prev_reg[sel_reg];
    wire [23:0] status_next = edge_seen ? hazard_of(sync2_reg) : status_reg;
    wire wr_sel = i_reg_wr && (i_reg_addr == sysref_window_pkg::TAP_SELECT_OFS);
    wire wr_step = i_reg_wr && (i_reg_addr == sysref_window_pkg::TAP_STEP_OFS);
    // Only these five offsets answer; anything else reads as zero
    wire addr_mapped = (i_reg_addr == sysref_window_pkg::STATUS_LOW_OFS) ||
        (i_reg_addr == sysref_window_pkg::STATUS_MID_OFS) ||
        (i_reg_addr == sysref_window_pkg::STATUS_HIGH_OFS) ||
        (i_reg_addr == sysref_window_pkg::TAP_SELECT_OFS) ||
        (i_reg_addr == sysref_window_pkg::TAP_STEP_OFS);
    // A falling SYSREF must leave the last measurement in place
    wire fall_seen = |(prev_reg & ~sync2_reg);
    logic [7:0] rdata_next;

    always_comb begin
        rdata_next = rdata_reg;
        if (i_reg_rd) begin
            unique case (i_reg_addr)
                sysref_window_pkg::STATUS_LOW_OFS: rdata_next = status_reg[7:0];
                sysref_window_pkg::STATUS_MID_OFS: rdata_next = status_reg[15:8];
                sysref_window_pkg::STATUS_HIGH_OFS: rdata_next = status_reg[23:16];
                sysref_window_pkg::TAP_SELECT_OFS: rdata_next = {4'h0, sel_reg};
                sysref_window_pkg::TAP_STEP_OFS: rdata_next = {7'h00, fine_reg};
                default: rdata_next = 8'h00;
            endcase
        end
    end

    // Taps come from the analog delay line, so they are synchronised first
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            sync1_reg <= 24'h000000;
            sync2_reg <= 24'h000000;
            prev_reg <= 24'h000000;
        end else begin
            sync1_reg <= i_tap_samples;
            sync2_reg <= sync1_reg;
            prev_reg <= sync2_reg;
        end
    end

    // Refreshed on every observed rising SYSREF edge, not only once
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            status_reg <= sysref_window_pkg::STATUS_RESET;
        end else begin
            status_reg <= status_next;
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            sel_reg <= sysref_window_pkg::TAP_SELECT_RESET;
            fine_reg <= sysref_window_pkg::TAP_STEP_RESET;
        end else begin
            if (wr_sel) begin
                sel_reg <= i_reg_wdata[3:0];
            end
            if (wr_step) begin
                fine_reg <= i_reg_wdata[sysref_window_pkg::STEP_FINE_BIT];
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rdata_reg <= 8'h00;
            counter_reset_reg <= 1'b0;
        end else begin
            rdata_reg <= rdata_next;
            counter_reset_reg <= sel_rise;
        end
    end

    assign o_reg_rdata = rdata_reg;
    assign o_counter_reset = counter_reset_reg;
    assign o_tap_step_fine = fine_reg;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);

    sequence tap_rise_s;
        sync2_reg[sel_reg] && !prev_reg[sel_reg];
    endsequence

    sequence sel_write_s;
        i_reg_wr && i_reg_addr == sysref_window_pkg::TAP_SELECT_OFS;
    endsequence

    sequence rd_s(logic [11:0] a);
        i_reg_rd && i_reg_addr == a;
    endsequence

    // Bytes are read one by one, so a status refresh between reads
    // can tear the 24-bit view; software should read twice to confirm
    status_mid_a: assert property (
        rd_s(sysref_window_pkg::STATUS_MID_OFS) |=>
        o_reg_rdata == $past(status_reg[15:8]))
        else $error("mid status byte misread");

    step_read_a: assert property (
        rd_s(sysref_window_pkg::TAP_STEP_OFS) |=>
        o_reg_rdata == {7'h00, $past(fine_reg)})
        else $error("fine step misread");

    sel_value_a: assert property (
        rd_s(sysref_window_pkg::TAP_SELECT_OFS) |=>
        o_reg_rdata[3:0] == $past(sel_reg))
        else $error("tap select misread");

    unmapped_read_a: assert property (i_reg_rd && !addr_mapped |=>
        o_reg_rdata == 8'h00)
        else $error("unmapped offset returned data");

    rdata_hold_a: assert property (!i_reg_rd |=> $stable(o_reg_rdata))
        else $error("read data moved without a read");

    // Only the second stage may read the first
    sync_chain_a: assert property (sync2_reg == $past(sync1_reg))
        else $error("tap synchroniser skipped a stage");

    sel_hold_a: assert property (!wr_sel |=> $stable(sel_reg))
        else $error("tap select changed without a write");

    step_hold_a: assert property (!wr_step |=> $stable(fine_reg))
        else $error("fine step changed without a write");

    counter_quiet_a: assert property (!sel_rise |=> !o_counter_reset)
        else $error("counter reset with no selected tap rise");

    fall_ignored_a: assert property (fall_seen && !edge_seen |=>
        $stable(status_reg))
        else $error("falling SYSREF altered status");

    status_ro_a: assert property (i_reg_wr && !edge_seen |=>
        $stable(status_reg))
        else $error("status written by register port");

    capture_pulse_a: assert property (tap_rise_s |=> o_counter_reset)
        else $error("selected tap edge did not reset counters");
    capture_cause_a: assert property (o_counter_reset |->
        $past(sync2_reg[sel_reg] && !prev_reg[sel_reg]))
        else $error("counter reset without selected tap edge");
    status_ends_a: assert property (status_reg[0] && status_reg[23])
        else $error("end status bits not set");
    status_refresh_a: assert property (edge_seen |=>
        status_reg == $past(hazard_of(sync2_reg)))
        else $error("status not refreshed on edge");
    status_hold_a: assert property (!edge_seen |=> $stable(status_reg))
        else $error("status changed without edge");
    sel_write_a: assert property (sel_write_s |=>
        sel_reg == $past(i_reg_wdata[3:0]))
        else $error("tap select not written");
    sel_apply_a: assert property (sel_write_s ##1 tap_rise_s |=>
        o_counter_reset)
        else $error("new tap select not applied");
    step_write_a: assert property (i_reg_wr &&
        i_reg_addr == sysref_window_pkg::TAP_STEP_OFS |=>
        o_tap_step_fine == $past(i_reg_wdata[0]))
        else $error("fine step not written");
    status_low_a: assert property (i_reg_rd &&
        i_reg_addr == sysref_window_pkg::STATUS_LOW_OFS |=>
        o_reg_rdata == $past(status_reg[7:0]))
        else $error("low status byte misread");
    status_high_a: assert property (i_reg_rd &&
        i_reg_addr == sysref_window_pkg::STATUS_HIGH_OFS |=>
        o_reg_rdata == $past(status_reg[23:16]))
        else $error("high status byte misread");
    sel_read_a: assert property (i_reg_rd &&
        i_reg_addr == sysref_window_pkg::TAP_SELECT_OFS |=>
        o_reg_rdata[7:4] == 4'h0)
        else $error("tap select reads above 15");
endmodule // sysref_capture_windowing
`default_nettype wire

// ### verilog/sysref_window_pkg.sv
// Constants for the SYSREF capture windowing block
// Contract
// - Capture SYSREF on deterministic clock edge
// - Sampling instants are delayed input clocks
// - Record SYSREF location, one bit per position
// - Status field holds 24 positions
// - One means hazard, zero means valid
// - Bits 0 and 23 always read one
// - Tap select is index of status bit
// - Tap select reaches positions 0 to 15
// - Fine step: 0 coarse, 1 fine
// - Status bytes at 0x02c, 0x02d, 0x02e
// - Captured edge resets multiframe counters
package sysref_window_pkg;
    localparam int unsigned POS_COUNT = 24;
    localparam int unsigned SEL_COUNT = 16;
    localparam int unsigned SEL_W = 4;
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 8;
    localparam logic [11:0] TAP_SELECT_OFS = 12'h029;
    localparam logic [11:0] TAP_STEP_OFS = 12'h02a;
    localparam logic [11:0] STATUS_LOW_OFS = 12'h02c;
    localparam logic [11:0] STATUS_MID_OFS = 12'h02d;
    localparam logic [11:0] STATUS_HIGH_OFS = 12'h02e;
    localparam int unsigned STEP_FINE_BIT = 0;
    localparam logic [3:0] TAP_SELECT_RESET = 4'h0;
    localparam logic TAP_STEP_RESET = 1'b1;
    localparam logic [23:0] STATUS_END_MASK = 24'h800001;
    localparam logic [23:0] STATUS_RESET = 24'hffffff;
endpackage
